// ### testbench.sv
// self-checking testbench of the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "ucm_defines.svh"
module testbench import ucm_pkg::*;;
  logic clk_sys, reset, clkEn, psel, penable, pwrite, txEngineOut, txHoldBusy, tx_empty_flag, active, sendBit, lastErr;
  logic pready, pslverr, rxLine, txLine, rxEngineIn, rxEnabled, txEnabled, breakActive, timeoutRun;
  logic addressPending, terminalReadyN, sendRequestN, syncMode, msbFirst;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] opMode;
  logic [2:0] parityMode;
  logic [9:0] ev;
  int fails, num_checks;

  ucm_control #(.IRW(8)) uut (.clk_sys, .reset, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rxLine, .txLine, .txEngineOut, .rxEngineIn, .rxEnabled, .txEnabled,
    .rxResetPulse(), .txResetPulse(), .txHoldBusy, .tx_empty_flag, .bitTick(ev[9]), .rxCharDone(ev[7]),
    .parityErrSet(ev[0]), .frameErrSet(ev[1]), .overrunErrSet(ev[2]), .breakRxSet(ev[3]),
    .timeoutSet(ev[4]), .iterSet(ev[5]), .nackSet(ev[6]), .breakActive, .timeoutRun, .timeoutRestart(),
    .addressPending, .thrWrite(ev[8]), .terminalReadyN, .sendRequestN, .opMode, .syncMode, .parityMode,
    .msbFirst);
  ucm_remote_station station (.clk_sys, .reset, .active, .sendBit, .txLine, .rxLine, .heard_q());

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // setup cycle, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    n = 1;
    while (pready !== 1'b1) begin
      if (n == 50) begin
        fails++;
        test_done();
      end
      @(posedge clk_sys);
      n++;
    end
    rdv = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic pulse(input logic [9:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 10'h000;
    #1;
  endtask : pulse

  task automatic tick(input int n);
    repeat (n) pulse(10'h200);
  endtask : tick

  function automatic logic [31:0] cb(input int b);
    return 32'h0000_0001 << b;
  endfunction : cb

  function automatic logic [31:0] mv(input logic [3:0] op, input logic [2:0] par, input logic [1:0] ch);
    return {15'h0000, 1'b0, ch, 2'h0, par, 1'b0, 4'h0, op};
  endfunction : mv

  task automatic t_regs();
    logic [7:0] z[6] = '{`UCM_OFF_IMR, `UCM_OFF_RHR, `UCM_OFF_BRG, `UCM_OFF_RTO, `UCM_OFF_TTG, `UCM_OFF_IF};
    logic [7:0] w[5] = '{`UCM_OFF_BRG, `UCM_OFF_RTO, `UCM_OFF_TTG, `UCM_OFF_IF, `UCM_OFF_FIDI};
    chk({terminalReadyN, sendRequestN}, 2'h3);
    rd(`UCM_OFF_FIDI);
    chk(rdv, 32'h0000_0174);
    foreach (z[i]) begin
      rd(z[i]);
      chk(rdv, 32'h0000_0000);
    end
    foreach (w[i]) begin
      wr(w[i], 32'h0000_00A5);
      rd(w[i]);
      chk(rdv, 32'h0000_00A5);
      chk(lastErr, 1'b0);
    end
    rd(8'h48);
    chk(rdv, 32'h0000_0000);
    chk(lastErr, 1'b1);
  endtask : t_regs

  task automatic t_modes();
    logic [3:0] ops[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
    logic [31:0] m;
    for (int i = 0; i < 7; i++) begin
      m = mv(ops[i], i[2:0], 2'h0) | (i[0] ? 32'h0000_0100 : 32'h0) | (i[1] ? 32'h0001_0000 : 32'h0);
      wr(`UCM_OFF_MODE, m);
      rd(`UCM_OFF_MODE);
      chk(rdv, m);
      chk(opMode, ops[i]);
      chk(parityMode, i[2:0]);
      chk({syncMode, msbFirst}, {i[0], i[1]});
    end
    wr(`UCM_OFF_MODE, 32'h0000_0000);
    // a write while the enable is low must not land
    @(posedge clk_sys);
    clkEn <= 1'b0;
    wr(`UCM_OFF_TTG, 32'h0000_005A);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    rd(`UCM_OFF_TTG);
    chk(rdv, 32'h0000_00A5);
  endtask : t_modes

  task automatic t_enable();
    wr(`UCM_OFF_CMD, cb(`UCM_C_RXON) | cb(`UCM_C_RXOFF));
    chk(rxEnabled, 1'b0);
    wr(`UCM_OFF_CMD, cb(`UCM_C_RXON) | cb(`UCM_C_TXON));
    chk({rxEnabled, txEnabled}, 2'h3);
    wr(`UCM_OFF_CMD, cb(`UCM_C_TXON) | cb(`UCM_C_TXOFF));
    chk({rxEnabled, txEnabled}, 2'h2);
    wr(`UCM_OFF_CMD, cb(`UCM_C_TX_RESET_CMD) | cb(`UCM_C_TXON));
    chk(txEnabled, 1'b1);
    wr(`UCM_OFF_CMD, 32'h0000_0000);
    chk({rxEnabled, txEnabled}, 2'h3);
  endtask : t_enable

  task automatic t_chan();
    for (int ch = 0; ch < 4; ch++) begin
      wr(`UCM_OFF_MODE, mv(4'h0, 3'h4, ch[1:0]));
      for (int v = 0; v < 4; v++) begin
        @(posedge clk_sys);
        active <= 1'b1;
        sendBit <= v[0];
        txEngineOut <= v[1];
        @(posedge clk_sys);
        #1;
        chk(txLine, ch == 0 ? v[1] : (ch == 2 ? 1'b1 : v[0]));
        if (ch != 3)
          chk(rxEngineIn, ch == 2 ? v[1] : v[0]);
      end
      chk({rxEnabled, txEnabled}, ch == 3 ? 2'h0 : 2'h3);
    end
    @(posedge clk_sys);
    active <= 1'b0;
    wr(`UCM_OFF_MODE, 32'h0000_0000);
  endtask : t_chan

  task automatic t_status();
    pulse(10'h00F);
    rd(`UCM_OFF_CSR);
    chk(rdv & 32'h0000_00E4, 32'h0000_00E4);
    wr(`UCM_OFF_CMD, cb(`UCM_C_STCLR));
    rd(`UCM_OFF_CSR);
    chk(rdv & 32'h0000_00E4, 32'h0000_0000);
    pulse(10'h060);
    wr(`UCM_OFF_CMD, cb(`UCM_C_ITCLR) | cb(`UCM_C_NKCLR));
    rd(`UCM_OFF_CSR);
    chk(rdv & 32'h0000_2400, 32'h0000_0400);
    wr(`UCM_OFF_MODE, mv(4'h4, 3'h4, 2'h0));
    wr(`UCM_OFF_CMD, cb(`UCM_C_ITCLR));
    rd(`UCM_OFF_CSR);
    chk(rdv & 32'h0000_0400, 32'h0000_0000);
    wr(`UCM_OFF_MODE, 32'h0000_0000);
    pulse(10'h010);
    wr(`UCM_OFF_CMD, cb(`UCM_C_TOARM));
    rd(`UCM_OFF_CSR);
    chk({rdv[`UCM_S_TIMEOUT], timeoutRun}, 2'h0);
    pulse(10'h000);
    chk(timeoutRun, 1'b0);
    pulse(10'h080);
    chk(timeoutRun, 1'b1);
  endtask : t_status

  task automatic t_irda();
    wr(`UCM_OFF_IF, 32'h0000_0003);
    wr(`UCM_OFF_MODE, mv(4'h8, 3'h4, 2'h0));
    @(posedge clk_sys);
    {active, sendBit} <= 2'h2;
    @(posedge clk_sys);
    active <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(rxEngineIn, 1'b1);
    @(posedge clk_sys);
    active <= 1'b1;
    repeat (8) @(posedge clk_sys);
    active <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(rxEngineIn, 1'b0);
    pulse(10'h200);
    chk(rxEngineIn, 1'b1);
    wr(`UCM_OFF_MODE, 32'h0000_0000);
  endtask : t_irda

  task automatic t_lines();
    wr(`UCM_OFF_CMD, cb(`UCM_C_DTRON));
    chk(terminalReadyN, 1'b0);
    wr(`UCM_OFF_CMD, cb(`UCM_C_DTROFF));
    chk(terminalReadyN, 1'b1);
    wr(`UCM_OFF_CMD, cb(`UCM_C_RTSON));
    chk(sendRequestN, 1'b0);
    wr(`UCM_OFF_CMD, cb(`UCM_C_RTSOFF));
    chk(sendRequestN, 1'b1);
    wr(`UCM_OFF_MODE, mv(4'h1, 3'h4, 2'h0));
    for (int e = 0; e < 2; e++) begin
      @(posedge clk_sys);
      tx_empty_flag <= e[0];
      @(posedge clk_sys);
      #1;
      chk(sendRequestN, !e[0]);
    end
    wr(`UCM_OFF_MODE, mv(4'h0, 3'h6, 2'h0));
    wr(`UCM_OFF_CMD, cb(`UCM_C_ADDR));
    chk(addressPending, 1'b1);
    pulse(10'h100);
    chk(addressPending, 1'b0);
    wr(`UCM_OFF_MODE, 32'h0000_0000);
    wr(`UCM_OFF_CMD, cb(`UCM_C_ADDR));
    chk(addressPending, 1'b0);
  endtask : t_lines

  task automatic t_break();
    int n;
    @(posedge clk_sys);
    txHoldBusy <= 1'b1;
    txEngineOut <= 1'b1;
    wr(`UCM_OFF_CMD, cb(`UCM_C_BRKON));
    tick(3);
    chk(breakActive, 1'b0);
    @(posedge clk_sys);
    txHoldBusy <= 1'b0;
    for (n = 0; breakActive !== 1'b1 && n < 40; n++)
      pulse(10'h000);
    chk({breakActive, txLine}, 2'h2);
    wr(`UCM_OFF_CMD, cb(`UCM_C_BRKOFF));
    tick(9);
    chk(breakActive, 1'b1);
    for (n = 0; breakActive !== 1'b0 && n < 40; n++)
      tick(1);
    chk(breakActive, 1'b0);
    @(posedge clk_sys);
    txEngineOut <= 1'b0;
    tick(10);
    chk(txLine, 1'b1);
    tick(4);
    chk(txLine, 1'b0);
    wr(`UCM_OFF_CMD, cb(`UCM_C_BRKOFF));
    chk(breakActive, 1'b0);
  endtask : t_break

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    test_done();
  end

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, txEngineOut, txHoldBusy, tx_empty_flag, active, sendBit} = 8'h00;
    clkEn = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ev = 10'h000;
    fails = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_modes();
    t_enable();
    t_chan();
    t_status();
    t_irda();
    t_lines();
    t_break();
    test_done();
  end
endmodule : testbench
`default_nettype wire

// ### ucm_control.sv
// serial transceiver command, mode and channel test-mode logic with APB registers
// Notes on behaviour
// R1: echo mode: receive line copied to transmit
// R2: local loopback: transmitter feeds receiver, line high
// R3: remote loopback: line straight through, engines off
// R4: channel mode 0..3 selects four paths
// R5: receiver enable only without disable
// R6: transmitter enable only without disable
// R7: status clear clears error flags; zeros ignored
// R8: break starts after pending data; waits while busy
// R9: break ends after char, 12 high bits
// R10: timeout arm clears flag, waits character
// R11: multidrop address command marks next character
// R12: iteration clear only in card modes
// R13: terminal-ready on drives low, off high
// R14: send-request on drives low, off high
// R15: operating mode field selects protocol mode
// R16: sync bit picks async or sync
// R17: parity field selects parity kind
// R18: bit order bit picks lsb/msb first
// R19: reset values of ratio and zeroed registers
// R20: infrared filter down counter on receive line
// R21: line-driver mode: send-request inverts tx empty
// R22: reset, then disable, then enable
// R23: software changes channel mode only when idle; the code applies a mode register write at any time, with no idle check
`timescale 1ns/1ps
`default_nettype none
`include "ucm_defines.svh"
module ucm_control import ucm_pkg::*; #(
  parameter int IRW = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset
  input wire logic clkEn, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic rxLine, // receive pin
  output logic txLine, // transmit pin
  input wire logic txEngineOut, // transmitter serial output
  output logic rxEngineIn, // receiver serial input
  output logic rxEnabled, // receiver enabled
  output logic txEnabled, // transmitter enabled
  output logic rxResetPulse, // receiver reset pulse
  output logic txResetPulse, // transmitter reset pulse
  input wire logic txHoldBusy, // holding or shift register occupied
  input wire logic tx_empty_flag, // transmitter empty flag
  input wire logic bitTick, // one bit period elapsed
  input wire logic rxCharDone, // character received pulse
  input wire logic parityErrSet, // parity error event
  input wire logic frameErrSet, // framing error event
  input wire logic overrunErrSet, // overrun event
  input wire logic breakRxSet, // break received event
  input wire logic timeoutSet, // timeout event
  input wire logic iterSet, // iteration event
  input wire logic nackSet, // nack event
  output logic breakActive, // transmitter sends break
  output logic timeoutRun, // timeout counter may count
  output logic timeoutRestart, // timeout rearm pulse
  output logic addressPending, // next char has address bit
  input wire logic thrWrite, // character written to holding
  output logic terminalReadyN, // terminal-ready pin, active low
  output logic sendRequestN, // send-request pin, active low
  output logic [3:0] opMode, // operating mode field
  output logic syncMode, // synchronous select
  output logic [2:0] parityMode, // parity field
  output logic msbFirst // bit order
);
  if (IRW < 1 || IRW > 32) begin : g_bad_width
    $error("ucm_control: bad filter width");
  end
  logic wr, rd;
  logic [31:0] cmd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign cmd = (wr && paddr == `UCM_OFF_CMD) ? pwdata : '0; // zeros do nothing [R7]

  // configuration registers
  logic [31:0] modeQ, modeD, imrQ, imrD, brgQ, brgD, rtoQ, rtoD, ttgQ, ttgD, fidiQ, fidiD, ifQ, ifD;
  always_comb begin
    modeD = modeQ;
    imrD = imrQ;
    brgD = brgQ;
    rtoD = rtoQ;
    ttgD = ttgQ;
    fidiD = fidiQ;
    ifD = ifQ;
    if (wr) begin
      case (paddr)
        `UCM_OFF_MODE: modeD = pwdata & `UCM_MODE_WMASK;
        `UCM_OFF_IER: imrD = imrQ | pwdata;
        `UCM_OFF_IDR: imrD = imrQ & ~pwdata;
        `UCM_OFF_BRG: brgD = pwdata;
        `UCM_OFF_RTO: rtoD = pwdata;
        `UCM_OFF_TTG: ttgD = pwdata;
        `UCM_OFF_FIDI: fidiD = pwdata;
        `UCM_OFF_IF: ifD = {{(32-IRW){1'b0}}, pwdata[IRW-1:0]};
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      modeQ <= `UCM_RST_MODE;
      imrQ <= `UCM_RST_ZERO; // [R19]
      brgQ <= `UCM_RST_ZERO; // [R19]
      rtoQ <= `UCM_RST_ZERO; // [R19]
      ttgQ <= `UCM_RST_ZERO; // [R19]
      fidiQ <= `UCM_RST_FIDI; // [R19]
      ifQ <= `UCM_RST_ZERO; // [R19]
    end else if (clkEn) begin
      modeQ <= modeD;
      imrQ <= imrD;
      brgQ <= brgD;
      rtoQ <= rtoD;
      ttgQ <= ttgD;
      fidiQ <= fidiD;
      ifQ <= ifD;
    end
  end
  ucm_channel_mode_field_t channel_mode_field;
  assign channel_mode_field = ucm_channel_mode_field_t'(modeQ[`UCM_M_CHANNEL_MODE_FIELD_LSB +: 2]); // [R4]
  assign opMode = modeQ[`UCM_M_OPMODE_LSB +: 4]; // [R15]
  assign syncMode = modeQ[`UCM_M_SYNC]; // [R16]
  assign parityMode = modeQ[`UCM_M_PAR_LSB +: 3]; // [R17]
  assign msbFirst = modeQ[`UCM_M_BITORDER]; // [R18]
  logic cardMode, irMode, multidrop;
  assign cardMode = opMode == UCM_OP_CARD_T0 || opMode == UCM_OP_CARD_T1;
  assign irMode = opMode == UCM_OP_INFRARED;
  assign multidrop = parityMode[2:1] == 2'b11;

  // enables, flags, modem lines
  logic rxEnQ, rxEnD, txEnQ, txEnD, dtrQ, dtrD, rtsQ, rtsD, addrQ, addrD, toWaitQ, toWaitD;
  logic [31:0] stQ, stD;
  always_comb begin
    rxEnD = rxEnQ;
    txEnD = txEnQ;
    if (cmd[`UCM_C_RX_RESET_CMD]) rxEnD = 1'b0; // [R22]
    if (cmd[`UCM_C_TX_RESET_CMD]) txEnD = 1'b0; // [R22]
    if (cmd[`UCM_C_RXOFF]) rxEnD = 1'b0; // [R5] [R22]
    else if (cmd[`UCM_C_RXON]) rxEnD = 1'b1; // [R5]
    if (cmd[`UCM_C_TXOFF]) txEnD = 1'b0; // [R6] [R22]
    else if (cmd[`UCM_C_TXON]) txEnD = 1'b1; // [R6]
    dtrD = dtrQ;
    if (cmd[`UCM_C_DTROFF]) dtrD = 1'b1; // [R13]
    else if (cmd[`UCM_C_DTRON]) dtrD = 1'b0; // [R13]
    rtsD = rtsQ;
    if (cmd[`UCM_C_RTSOFF]) rtsD = 1'b1; // [R14]
    else if (cmd[`UCM_C_RTSON]) rtsD = 1'b0; // [R14]
    addrD = addrQ;
    if (thrWrite) addrD = 1'b0;
    if (cmd[`UCM_C_ADDR] && multidrop) addrD = 1'b1; // [R11]
    toWaitD = toWaitQ;
    if (rxCharDone) toWaitD = 1'b0;
    if (cmd[`UCM_C_TOARM]) toWaitD = 1'b1; // [R10]
    stD = stQ;
    if (cmd[`UCM_C_STCLR]) begin
      stD[`UCM_S_PARITY_ERROR_FLAG] = 1'b0; // [R7]
      stD[`UCM_S_FRAME] = 1'b0;
      stD[`UCM_S_OVERRUN_ERROR_FLAG] = 1'b0;
      stD[`UCM_S_BREAK_RECEIVED_FLAG] = 1'b0;
    end
    if (cmd[`UCM_C_TOARM]) stD[`UCM_S_TIMEOUT] = 1'b0; // [R10]
    if (cmd[`UCM_C_ITCLR] && cardMode) stD[`UCM_S_ITER] = 1'b0; // [R12]
    if (cmd[`UCM_C_NKCLR]) stD[`UCM_S_NACK] = 1'b0;
    // events win over a clear in the same cycle
    if (parityErrSet) stD[`UCM_S_PARITY_ERROR_FLAG] = 1'b1;
    if (frameErrSet) stD[`UCM_S_FRAME] = 1'b1;
    if (overrunErrSet) stD[`UCM_S_OVERRUN_ERROR_FLAG] = 1'b1;
    if (breakRxSet) stD[`UCM_S_BREAK_RECEIVED_FLAG] = 1'b1;
    if (timeoutSet) stD[`UCM_S_TIMEOUT] = 1'b1;
    if (iterSet) stD[`UCM_S_ITER] = 1'b1;
    if (nackSet) stD[`UCM_S_NACK] = 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxEnQ <= 1'b0;
      txEnQ <= 1'b0;
      dtrQ <= 1'b1;
      rtsQ <= 1'b1;
      addrQ <= 1'b0;
      toWaitQ <= 1'b0;
      stQ <= `UCM_RST_ZERO;
    end else if (clkEn) begin
      rxEnQ <= rxEnD;
      txEnQ <= txEnD;
      dtrQ <= dtrD;
      rtsQ <= rtsD;
      addrQ <= addrD;
      toWaitQ <= toWaitD;
      stQ <= stD;
    end
  end
  assign rxResetPulse = cmd[`UCM_C_RX_RESET_CMD]; // [R22]
  assign txResetPulse = cmd[`UCM_C_TX_RESET_CMD]; // [R22]
  assign rxEnabled = rxEnQ && channel_mode_field != UCM_CH_REMOTE; // [R3]
  assign txEnabled = txEnQ && channel_mode_field != UCM_CH_REMOTE; // [R3]
  assign terminalReadyN = dtrQ;
  assign sendRequestN = (opMode == UCM_OP_LINEDRV) ? !tx_empty_flag : rtsQ; // [R21]
  assign addressPending = addrQ;
  assign timeoutRun = !toWaitQ; // [R10]
  assign timeoutRestart = cmd[`UCM_C_TOREARM];

  // break sequencer
  ucm_brk_t brkQ, brkD;
  logic [7:0] bcQ, bcD;
  always_comb begin
    brkD = brkQ;
    bcD = bcQ;
    case (brkQ)
      UCM_BRK_IDLE: if (cmd[`UCM_C_BRKON]) brkD = UCM_BRK_WAIT;
      UCM_BRK_WAIT: if (!txHoldBusy) begin // [R8]
        brkD = UCM_BRK_SEND;
        bcD = '0;
      end
      UCM_BRK_SEND: begin
        if (bitTick && {1'b0, bcQ[6:0]} < `UCM_BRK_MIN_BITS) bcD = bcQ + 8'd1; // count ignores stop flag
        if (cmd[`UCM_C_BRKOFF] || bcQ[7]) bcD[7] = 1'b1; // stop latched
        if (bcD[7] && {1'b0, bcD[6:0]} >= `UCM_BRK_MIN_BITS) begin // [R9]
          brkD = UCM_BRK_HIGH;
          bcD = '0;
        end
      end
      UCM_BRK_HIGH: begin
        if (bitTick) bcD = bcQ + 8'd1;
        if (bcQ == `UCM_BRK_HIGH_BITS) brkD = UCM_BRK_IDLE; // [R9]
      end
      default: brkD = UCM_BRK_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      brkQ <= UCM_BRK_IDLE;
      bcQ <= '0;
    end else if (clkEn) begin
      brkQ <= brkD;
      bcQ <= bcD;
    end
  end
  assign breakActive = brkQ == UCM_BRK_SEND;

  // line routing per channel mode
  logic rxFilt;
  ucm_ir_filter #(.CW(IRW)) uFilt (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .active(irMode),
    .bitTick(bitTick),
    .loadVal(ifQ[IRW-1:0]),
    .rxIn(rxLine),
    .rxOut(rxFilt)
  );
  logic txDrive;
  assign txDrive = breakActive ? 1'b0 : (brkQ == UCM_BRK_HIGH) ? 1'b1 : txEngineOut; // [R9]
  always_comb begin
    case (channel_mode_field)
      UCM_CH_ECHO: begin
        txLine = rxLine; // [R1]
        rxEngineIn = rxFilt; // [R1]
      end
      UCM_CH_LOCAL: begin
        txLine = 1'b1; // [R2]
        rxEngineIn = txDrive; // [R2]
      end
      UCM_CH_REMOTE: begin
        txLine = rxLine; // [R3]
        rxEngineIn = 1'b1;
      end
      default: begin
        txLine = txDrive;
        rxEngineIn = rxFilt;
      end
    endcase
  end

  // read mux
  logic [31:0] rdD, rdQ;
  logic errD, errQ;
  always_comb begin
    rdD = '0;
    errD = 1'b0;
    case (paddr)
      `UCM_OFF_MODE: rdD = modeQ;
      `UCM_OFF_IMR: rdD = imrQ;
      `UCM_OFF_CSR: rdD = stQ | ({31'h0, tx_empty_flag} << `UCM_S_TX_EMPTY_FLAG)
                          | ({31'h0, txEnQ && !txHoldBusy} << `UCM_S_TXRDY);
      `UCM_OFF_BRG: rdD = brgQ;
      `UCM_OFF_RTO: rdD = rtoQ;
      `UCM_OFF_TTG: rdD = ttgQ;
      `UCM_OFF_FIDI: rdD = fidiQ;
      `UCM_OFF_IF: rdD = ifQ;
      `UCM_OFF_RHR, `UCM_OFF_NER, `UCM_OFF_CMD, `UCM_OFF_IER, `UCM_OFF_IDR, `UCM_OFF_THR: rdD = '0;
      default: errD = 1'b1;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdQ <= '0;
      errQ <= 1'b0;
    end else if (clkEn) begin
      rdQ <= rdD;
      errQ <= errD;
    end
  end
  assign prdata = rd ? rdD : rdQ;
  assign pslverr = psel && penable && errD;

  // checks
  property p_echo;
    @(posedge clk_sys) disable iff (reset) channel_mode_field == UCM_CH_ECHO |-> txLine == rxLine;
  endproperty
  a_echo: assert property (p_echo) else $error("echo path broken"); // [R1]
  property p_local;
    @(posedge clk_sys) disable iff (reset) channel_mode_field == UCM_CH_LOCAL |-> txLine && rxEngineIn == txDrive;
  endproperty
  a_local: assert property (p_local) else $error("local loopback wrong"); // [R2]
  property p_remote;
    @(posedge clk_sys) disable iff (reset) channel_mode_field == UCM_CH_REMOTE |-> txLine == rxLine && !rxEnabled && !txEnabled;
  endproperty
  a_remote: assert property (p_remote) else $error("remote loopback wrong"); // [R3]
  property p_rx_disable_cmd;
    @(posedge clk_sys) disable iff (reset) clkEn && cmd[`UCM_C_RXOFF] |=> !rxEnQ;
  endproperty
  a_rx_disable_cmd: assert property (p_rx_disable_cmd) else $error("receiver disable lost"); // [R5]
  property p_tx_enable_cmd;
    @(posedge clk_sys) disable iff (reset)
      clkEn && cmd[`UCM_C_TXON] && !cmd[`UCM_C_TXOFF] |=> txEnQ;
  endproperty
  a_tx_enable_cmd: assert property (p_tx_enable_cmd) else $error("transmitter enable lost"); // [R6]
  property p_stclr;
    @(posedge clk_sys) disable iff (reset)
      clkEn && cmd[`UCM_C_STCLR] && !parityErrSet |=> !stQ[`UCM_S_PARITY_ERROR_FLAG];
  endproperty
  a_stclr: assert property (p_stclr) else $error("parity flag not cleared"); // [R7]
  property p_brkwait;
    @(posedge clk_sys) disable iff (reset) brkQ == UCM_BRK_WAIT && txHoldBusy && clkEn |=> !breakActive;
  endproperty
  a_brkwait: assert property (p_brkwait) else $error("break began early"); // [R8]
  property p_brkhigh;
    @(posedge clk_sys) disable iff (reset) brkQ == UCM_BRK_HIGH && channel_mode_field == UCM_CH_NORMAL |-> txLine;
  endproperty
  a_brkhigh: assert property (p_brkhigh) else $error("break trailer not high"); // [R9]
  property p_dtr;
    @(posedge clk_sys) disable iff (reset)
      clkEn && cmd[`UCM_C_DTRON] && !cmd[`UCM_C_DTROFF] |=> !terminalReadyN;
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready not low"); // [R13]
  property p_rts;
    @(posedge clk_sys) disable iff (reset)
      clkEn && opMode != UCM_OP_LINEDRV && cmd[`UCM_C_RTSOFF] |=> sendRequestN || opMode == UCM_OP_LINEDRV;
  endproperty
  a_rts: assert property (p_rts) else $error("send request not high"); // [R14]
endmodule : ucm_control
`default_nettype wire

// ### ucm_defines.svh
// register offsets, field positions and reset values of the serial control block
`ifndef UCM_DEFINES_SVH
`define UCM_DEFINES_SVH
`define UCM_OFF_CMD 8'h00
`define UCM_OFF_MODE 8'h04
`define UCM_OFF_IER 8'h08
`define UCM_OFF_IDR 8'h0C
`define UCM_OFF_IMR 8'h10
`define UCM_OFF_CSR 8'h14
`define UCM_OFF_RHR 8'h18
`define UCM_OFF_THR 8'h1C
`define UCM_OFF_BRG 8'h20
`define UCM_OFF_RTO 8'h24
`define UCM_OFF_TTG 8'h28
`define UCM_OFF_FIDI 8'h40
`define UCM_OFF_NER 8'h44
`define UCM_OFF_IF 8'h4C
`define UCM_RST_FIDI 32'h0000_0174
`define UCM_RST_ZERO 32'h0000_0000
`define UCM_RST_MODE 32'h0000_0000
`define UCM_MODE_WMASK 32'h173F_FFFF
// command bits
`define UCM_C_RX_RESET_CMD 2
`define UCM_C_TX_RESET_CMD 3
`define UCM_C_RXON 4
`define UCM_C_RXOFF 5
`define UCM_C_TXON 6
`define UCM_C_TXOFF 7
`define UCM_C_STCLR 8
`define UCM_C_BRKON 9
`define UCM_C_BRKOFF 10
`define UCM_C_TOARM 11
`define UCM_C_ADDR 12
`define UCM_C_ITCLR 13
`define UCM_C_NKCLR 14
`define UCM_C_TOREARM 15
`define UCM_C_DTRON 16
`define UCM_C_DTROFF 17
`define UCM_C_RTSON 18
`define UCM_C_RTSOFF 19
// mode fields
`define UCM_M_OPMODE_LSB 0
`define UCM_M_SYNC 8
`define UCM_M_PAR_LSB 9
`define UCM_M_CHANNEL_MODE_FIELD_LSB 14
`define UCM_M_BITORDER 16
// status bits
`define UCM_S_RXRDY 0
`define UCM_S_TXRDY 1
`define UCM_S_BREAK_RECEIVED_FLAG 2
`define UCM_S_OVERRUN_ERROR_FLAG 5
`define UCM_S_FRAME 6
`define UCM_S_PARITY_ERROR_FLAG 7
`define UCM_S_TIMEOUT 8
`define UCM_S_TX_EMPTY_FLAG 9
`define UCM_S_ITER 10
`define UCM_S_NACK 13
// timing in bit periods
`define UCM_BRK_MIN_BITS 8'd10
`define UCM_BRK_HIGH_BITS 8'd12
`endif

// ### ucm_ir_filter.sv
// infrared receive filter: down counter that rejects short low pulses
`timescale 1ns/1ps
`default_nettype none
module ucm_ir_filter #(
  parameter int CW = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset
  input wire logic clkEn, // clock enable
  input wire logic active, // infrared mode selected
  input wire logic bitTick, // one bit period elapsed
  input wire logic [CW-1:0] loadVal, // filter reload value
  input wire logic rxIn, // raw receive line
  output logic rxOut // filtered receive line
);
  if (CW < 1) begin : g_bad_width
    $error("ucm_ir_filter: width too small");
  end
  logic prevQ, prevD, runQ, runD, lowQ, lowD;
  logic [CW-1:0] cntQ, cntD;
  always_comb begin
    prevD = rxIn;
    runD = runQ;
    cntD = cntQ;
    lowD = lowQ;
    if (!active) begin
      runD = 1'b0;
      cntD = loadVal;
      lowD = 1'b0;
    end else begin
      if (prevQ && !rxIn) begin
        runD = 1'b1; // [R20]
        cntD = loadVal;
      end else if (!prevQ && rxIn) begin
        runD = 1'b0; // [R20]
        cntD = loadVal;
      end else if (runQ) begin
        if (cntQ == '0) begin
          runD = 1'b0;
          lowD = 1'b1; // [R20]
        end else begin
          cntD = cntQ - 1'b1;
        end
      end
      if (lowQ && bitTick) lowD = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prevQ <= 1'b1;
      runQ <= 1'b0;
      cntQ <= '0;
      lowQ <= 1'b0;
    end else if (clkEn) begin
      prevQ <= prevD;
      runQ <= runD;
      cntQ <= cntD;
      lowQ <= lowD;
    end
  end
  assign rxOut = active ? !lowQ : rxIn;
endmodule : ucm_ir_filter
`default_nettype wire

// ### ucm_pkg.sv
// types of the serial control block
package ucm_pkg;
  typedef enum logic [1:0] {
    UCM_CH_NORMAL = 2'h0,
    UCM_CH_ECHO = 2'h1,
    UCM_CH_LOCAL = 2'h2,
    UCM_CH_REMOTE = 2'h3
  } ucm_channel_mode_field_t;
  typedef enum logic [3:0] {
    UCM_OP_NORMAL = 4'h0,
    UCM_OP_LINEDRV = 4'h1,
    UCM_OP_HANDSHAKE = 4'h2,
    UCM_OP_MODEM = 4'h3,
    UCM_OP_CARD_T0 = 4'h4,
    UCM_OP_CARD_T1 = 4'h6,
    UCM_OP_INFRARED = 4'h8
  } ucm_opmode_t;
  typedef enum logic [3:0] {
    UCM_BRK_IDLE = 4'b0001,
    UCM_BRK_WAIT = 4'b0010,
    UCM_BRK_SEND = 4'b0100,
    UCM_BRK_HIGH = 4'b1000
  } ucm_brk_t;
endpackage : ucm_pkg

// ### ucm_remote_station.sv
// remote serial station model that drives the receive line and watches the transmit line
`timescale 1ns/1ps
`default_nettype none
module ucm_remote_station (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset
  input wire logic active, // frame in progress
  input wire logic sendBit, // bit to place on the line
  input wire logic txLine, // device transmit pin
  output logic rxLine, // device receive pin
  output logic [7:0] heard_q // last bits seen on the transmit pin
);
  // idle line rests high, as a marking line does
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxLine <= 1'b1;
      heard_q <= 8'h00;
    end else begin
      rxLine <= active ? sendBit : 1'b1;
      heard_q <= {heard_q[6:0], txLine};
    end
  end
endmodule : ucm_remote_station
`default_nettype wire
